/* File: rtl/gpap_port.sv */
// GPIO block with per-pin input, output or alternate function.
// Assumes pins are asynchronous and core-side alternate signals share clk_i.
//
// Operation
// R1: Eleven pins, each configured on its own.
// R2: Fixed alternate function assigned to each pin; pins 5, 6 and 8 have none here and stay undriven in alternate mode.
// R3: Reset leaves all pins as inputs.
// R4: Inputs synchronised, sampled at most every 128 ns.
// R5: General purpose pins hold alternate logic inactive.
// R6: Each pin owns one bit per register.
// R7: Function and direction bits decode pin mode.
// R8: Input mode captures pin level into data.
// R9: Data reads return sampled level, any mode.
// R10: Output mode drives the data latch value.
// R11: Alternate mode gives pin to alternate logic.
// R12: Three registers sit in upstream configuration space.
// R13: Data writes go to separate output latch.
//
// The address-and-strobe port and the address map were chosen for this implementation.
`timescale 1ns/10ps

module gpap_port (
    // Clock and reset.
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Register port.
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // Pins.
    input  wire logic [10:0] pin_i,
    output logic      [10:0] pin_o,
    output logic      [10:0] pin_oe_o,
    // Alternate function sources from the core.
    input  wire logic        port2_reset_out_n_i,
    input  wire logic        port3_reset_out_n_i,
    input  wire logic        port4_reset_out_n_i,
    input  wire logic        port5_reset_out_n_i,
    input  wire logic        general_event_out_n_i,
    // Alternate function inputs toward the core.
    output logic      [2:0]  expander_irq_n_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // Mode decode.

    function automatic gpap_pkg::gpap_mode_e pin_mode(input logic func, input logic dir);
        if (func) begin
            return gpap_pkg::MODE_ALT;
        end
        else if (dir) begin
            return gpap_pkg::MODE_OUT;
        end
        return gpap_pkg::MODE_IN;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [10:0] pin_function_select;
    logic [10:0] pin_direction_config;
    logic [10:0] out_latch;
    logic [10:0] pin_data_value;
    logic [10:0] sync1;
    logic [10:0] sync2;
    logic [1:0]  sample_cnt;
    wire  [2:0]  next_irq_n;
    wire  [10:0] next_pin_o;
    wire  [10:0] next_pin_oe;
    logic [10:0] alt_val;
    logic [31:0] next_rdata;

    wire         hit_func   = reg_addr_i == gpap_pkg::OFS_FUNC;
    wire         hit_dir    = reg_addr_i == gpap_pkg::OFS_DIR;
    wire         hit_data   = reg_addr_i == gpap_pkg::OFS_DATA;
    wire         sample_en  = sample_cnt == gpap_pkg::SAMPLE_LAST;
    wire  [10:0] wdata_pins = reg_wdata_i[10:0];

    // Upper bits read as zero; an unmapped address reads as zero.
    assign next_rdata = hit_func ? {21'h000000, pin_function_select} :  // R12
                        hit_dir  ? {21'h000000, pin_direction_config} : // R12
                        hit_data ? {21'h000000, pin_data_value} :       // R9
                        32'h00000000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_function_select  <= gpap_pkg::RST_FUNC;  // R3
            pin_direction_config <= gpap_pkg::RST_DIR;   // R3
            out_latch            <= gpap_pkg::RST_LATCH;
            reg_rdata_o          <= 32'h00000000;
        end
        else begin
            if (reg_wr_i && hit_func) begin
                pin_function_select <= wdata_pins;  // R6
            end
            if (reg_wr_i && hit_dir) begin
                pin_direction_config <= wdata_pins; // R6
            end
            if (reg_wr_i && hit_data) begin
                out_latch <= wdata_pins;            // R13
            end
            reg_rdata_o <= reg_rd_i ? next_rdata : 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Input synchroniser and slow sampler.
    // Sampling every pin in every mode lets software read back what is really on the wire.

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sync1          <= 11'h000;
            sync2          <= 11'h000;
            sample_cnt     <= 2'h0;
            pin_data_value <= 11'h000;
        end
        else begin
            sync1      <= pin_i;                                   // R4
            sync2      <= sync1;                                   // R4
            sample_cnt <= sample_en ? 2'h0 : sample_cnt + 2'h1;     // R4
            if (sample_en) begin
                pin_data_value <= sync2;                           // R8
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Pin drivers.

    assign alt_val = {port5_reset_out_n_i, port3_reset_out_n_i, 1'b1,
                      general_event_out_n_i, 5'h1F,
                      port4_reset_out_n_i, port2_reset_out_n_i};   // R2

    genvar g;
    generate
        for (g = 0; g < gpap_pkg::NUM_PINS; g++) begin : g_pin
            gpap_pkg::gpap_mode_e mode;
            assign mode = pin_mode(pin_function_select[g], pin_direction_config[g]); // R7
            // Pins with no alternate output stay undriven in alternate mode.
            assign next_pin_oe[g] = (mode == gpap_pkg::MODE_OUT) ||
                                    (mode == gpap_pkg::MODE_ALT && gpap_pkg::ALT_OUT[g]); // R11
            assign next_pin_o[g]  = (mode == gpap_pkg::MODE_ALT) ? alt_val[g] : out_latch[g]; // R10
        end
        for (g = 0; g < 3; g++) begin : g_irq
            // An unselected interrupt reads as inactive so the expander logic sees no event.
            assign next_irq_n[g] = pin_function_select[gpap_pkg::IRQ0_PIN + g] ?
                                   sync2[gpap_pkg::IRQ0_PIN + g] : 1'b1; // R5
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin_o            <= 11'h000;
            pin_oe_o         <= 11'h000;  // R3
            expander_irq_n_o <= 3'h7;     // R5
        end
        else begin
            pin_o            <= next_pin_o;
            pin_oe_o         <= next_pin_oe;  // R1
            expander_irq_n_o <= next_irq_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_reset_inputs;
        $past(rst_i) |-> (pin_oe_o == 11'h000 && expander_irq_n_o == 3'h7);
    endproperty
    a_reset_inputs: assert property (p_reset_inputs) else $error("Pin driven after reset."); // R3

    property p_sample_hold;
        !sample_en |=> $stable(pin_data_value);
    endproperty
    a_sample_hold: assert property (p_sample_hold) else $error("Sample changed off its slot."); // R4

    property p_sample_spacing;
        sample_en |=> !sample_en [*2];
    endproperty
    a_sample_spacing: assert property (p_sample_spacing) else $error("Samples too close."); // R4

    property p_irq_inactive;
        !pin_function_select[3] |=> expander_irq_n_o[1];
    endproperty
    a_irq_inactive: assert property (p_irq_inactive) else $error("Unselected interrupt active."); // R5

    property p_out_drive;
        (!pin_function_select[5] && pin_direction_config[5]) |=> (pin_oe_o[5] && pin_o[5] == $past(out_latch[5]));
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("Output pin not driven from latch."); // R10

    property p_in_float;
        (!pin_function_select[6] && !pin_direction_config[6]) |=> !pin_oe_o[6];
    endproperty
    a_in_float: assert property (p_in_float) else $error("Input pin is driven."); // R7

    property p_alt_drive;
        pin_function_select[7] |=> (pin_oe_o[7] && pin_o[7] == $past(general_event_out_n_i));
    endproperty
    a_alt_drive: assert property (p_alt_drive) else $error("Event pin not under alternate logic."); // R11

    property p_alt_reset;
        pin_function_select[9] |=> (pin_o[9] == $past(port3_reset_out_n_i));
    endproperty
    a_alt_reset: assert property (p_alt_reset) else $error("Port reset pin mismapped."); // R2

    property p_data_read;
        (reg_rd_i && hit_data) |=> reg_rdata_o == {21'h000000, $past(pin_data_value)};
    endproperty
    a_data_read: assert property (p_data_read) else $error("Data read not sampled level."); // R9

    property p_latch_write;
        (reg_wr_i && hit_data) |=> (out_latch == $past(wdata_pins));
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("Data write missed latch."); // R13

    property p_func_write;
        (reg_wr_i && hit_func) |=> (pin_function_select == $past(wdata_pins));
    endproperty
    a_func_write: assert property (p_func_write) else $error("Function write lost."); // R6

    property p_read_idle;
        !reg_rd_i |=> reg_rdata_o == 32'h00000000;
    endproperty
    a_read_idle: assert property (p_read_idle) else $error("Read data outside its cycle."); // R12

    // Alternate pins are checked one by one, since a swapped wire shows on a single pin only.
    property p_alt_port2;
        pin_function_select[0] |=> (pin_oe_o[0] && pin_o[0] == $past(port2_reset_out_n_i));
    endproperty
    a_alt_port2: assert property (p_alt_port2) else $error("Port 2 reset pin mismapped."); // R2

    property p_alt_port4;
        pin_function_select[1] |=> (pin_oe_o[1] && pin_o[1] == $past(port4_reset_out_n_i));
    endproperty
    a_alt_port4: assert property (p_alt_port4) else $error("Port 4 reset pin mismapped."); // R2

    property p_alt_port5;
        pin_function_select[10] |=> (pin_oe_o[10] && pin_o[10] == $past(port5_reset_out_n_i));
    endproperty
    a_alt_port5: assert property (p_alt_port5) else $error("Port 5 reset pin mismapped."); // R2

    property p_irq_follow;
        pin_function_select[2] |=> (expander_irq_n_o[0] == $past(sync2[2]));
    endproperty
    a_irq_follow: assert property (p_irq_follow) else $error("Interrupt does not follow its pin."); // R2

    // A driven listening or spare pin would fight whatever the board puts on it.
    property p_alt_listen;
        pin_function_select[4] |=> !pin_oe_o[4];
    endproperty
    a_alt_listen: assert property (p_alt_listen) else $error("Interrupt pin is driven."); // R11

    property p_alt_spare;
        pin_function_select[8] |=> !pin_oe_o[8];
    endproperty
    a_alt_spare: assert property (p_alt_spare) else $error("Spare pin is driven."); // R11

    property p_reset_regs;
        $past(rst_i) |-> (pin_function_select == gpap_pkg::RST_FUNC && pin_direction_config == gpap_pkg::RST_DIR);
    endproperty
    a_reset_regs: assert property (p_reset_regs) else $error("Pin mode not input after reset."); // R3

    property p_dir_write;
        (reg_wr_i && hit_dir) |=> (pin_direction_config == $past(wdata_pins));
    endproperty
    a_dir_write: assert property (p_dir_write) else $error("Direction write lost."); // R6

    property p_func_hold;
        !(reg_wr_i && hit_func) |=> $stable(pin_function_select);
    endproperty
    a_func_hold: assert property (p_func_hold) else $error("Function changed without a write."); // R6

    property p_dir_hold;
        !(reg_wr_i && hit_dir) |=> $stable(pin_direction_config);
    endproperty
    a_dir_hold: assert property (p_dir_hold) else $error("Direction changed without a write."); // R6

    property p_latch_hold;
        !(reg_wr_i && hit_data) |=> $stable(out_latch);
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("Latch changed without a write."); // R13

    property p_gpio_latch;
        !pin_function_select[0] |=> (pin_o[0] == $past(out_latch[0]));
    endproperty
    a_gpio_latch: assert property (p_gpio_latch) else $error("Alternate value leaks onto general pin."); // R5

    property p_sample_take;
        sample_en |=> (pin_data_value == $past(sync2));
    endproperty
    a_sample_take: assert property (p_sample_take) else $error("Sample slot missed the pin level."); // R8

    property p_sample_range;
        !(sample_cnt > gpap_pkg::SAMPLE_LAST);
    endproperty
    a_sample_range: assert property (p_sample_range) else $error("Sample counter out of range."); // R4

    property p_func_read;
        (reg_rd_i && hit_func) |=> reg_rdata_o == {21'h000000, $past(pin_function_select)};
    endproperty
    a_func_read: assert property (p_func_read) else $error("Function read wrong."); // R12

endmodule

/* File: shared/gpap_pkg.sv */
// Constants shared by the GPIO alternate function port.
// Assumes a 20 MHz core clock and a simple strobe register port.
package gpap_pkg;

    localparam int          NUM_PINS   = 11;
    localparam int          ADDR_W     = 8;
    localparam int          DATA_W     = 32;

    // Register byte offsets.
    localparam logic [7:0]  OFS_FUNC   = 8'h00;
    localparam logic [7:0]  OFS_DIR    = 8'h04;
    localparam logic [7:0]  OFS_DATA   = 8'h08;

    // Values after reset: every pin is a general purpose input.
    localparam logic [10:0] RST_FUNC   = 11'h000;
    localparam logic [10:0] RST_DIR    = 11'h000;
    localparam logic [10:0] RST_LATCH  = 11'h000;

    // Pins whose alternate function drives, and pins whose alternate function listens.
    localparam logic [10:0] ALT_OUT    = 11'h683;
    localparam logic [10:0] ALT_IN     = 11'h01C;
    localparam int          IRQ0_PIN   = 2;

    // Least input sampling interval.
    localparam int          CLK_NS     = 50;
    localparam int          SAMPLE_NS  = 128;
    localparam int          SAMPLE_CYC = (SAMPLE_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [1:0]  SAMPLE_LAST = 2'(SAMPLE_CYC - 1);

    typedef enum logic [1:0] {
        MODE_IN,
        MODE_OUT,
        MODE_ALT
    } gpap_mode_e;

endpackage

/* File: sim/gpap_port_tb.sv */
// Self-checking bench for the GPIO alternate function port.
// Assumes the design drives read data one cycle after a read strobe and nothing stalls.
`timescale 1ns/10ps

module gpap_port_tb;
    logic        clk_i;
    logic        rst_i;
    logic [7:0]  reg_addr_i;
    logic [31:0] reg_wdata_i;
    logic        reg_wr_i;
    logic        reg_rd_i;
    logic [31:0] reg_rdata_o;
    logic [10:0] pin_i;
    logic [10:0] pin_o;
    logic [10:0] pin_oe_o;
    logic        p2_n, p3_n, p4_n, p5_n, ev_n;
    logic [2:0]  expander_irq_n_o;
    logic        rd_q = 1'b0;
    logic [15:0] lfsr_st = 16'h0018;
    logic [10:0] v, d, pe;
    logic [4:0]  a;
    logic [31:0] exp_q[$];
    int          fails = 0;
    int          n_tests = 0;

    gpap_port dut (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .port2_reset_out_n_i(p2_n), .port3_reset_out_n_i(p3_n),
        .port4_reset_out_n_i(p4_n), .port5_reset_out_n_i(p5_n), .general_event_out_n_i(ev_n),
        .expander_irq_n_o(expander_irq_n_o));

    ////////////////////////////////////////////////////////////////////////////////////////////
    function automatic logic [10:0] rnd();
        lfsr_st = {lfsr_st[14:0], lfsr_st[15] ^ lfsr_st[13] ^ lfsr_st[12] ^ lfsr_st[10]};
        return lfsr_st[10:0];
    endfunction

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %0h seen %0h", name, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] ad, input logic [10:0] val);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= ad;
        reg_wdata_i <= 32'(val);
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    // The expectation is queued now and checked by the watcher below.
    task automatic rd(input logic [7:0] ad, input logic [10:0] e);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= ad;
        exp_q.push_back(32'(e));
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
    endtask

    task automatic wrap_up();
        if (fails == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    always @(posedge clk_i) rd_q <= reg_rd_i;

    // Read data stands only in the cycle after the strobe, so it is taken mid-cycle there.
    always @(negedge clk_i) begin
        if (rd_q === 1'b1)
            chk("read data", exp_q.pop_front(), reg_rdata_o);
    end

    initial begin
        #(50 * 2000);
        fails++;
        wrap_up();
    end

    initial begin
        {rst_i, reg_wr_i, reg_rd_i, reg_addr_i, reg_wdata_i, pin_i} = '0;
        {p2_n, p3_n, p4_n, p5_n, ev_n} = 5'h1F;
        rst_i = 1'b1;
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("pin_oe", 32'h0, 32'(pin_oe_o));
        chk("irq", 32'h7, 32'(expander_irq_n_o));
        rd(gpap_pkg::OFS_FUNC, 11'h000);
        rd(gpap_pkg::OFS_DIR, 11'h000);
        rd(8'h0C, 11'h000);
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            d = rnd();
            wr(gpap_pkg::OFS_DIR, v);
            wr(gpap_pkg::OFS_DATA, d);
            pin_i <= rnd();
            repeat (8) @(posedge clk_i);
            chk("pin_oe", 32'(v), 32'(pin_oe_o));
            chk("pin_o", 32'(d & v), 32'(pin_o & v));
            rd(gpap_pkg::OFS_DIR, v);
            rd(gpap_pkg::OFS_DATA, pin_i);
        end
        // Direction is left nonzero so that alternate mode must ignore it.
        wr(gpap_pkg::OFS_FUNC, 11'h7FF);
        for (int i = 0; i < 4; i++) begin
            a = 5'(rnd());
            {p5_n, p3_n, ev_n, p4_n, p2_n} <= a;
            pe = {a[4], a[3], 1'b0, a[2], 5'h00, a[1], a[0]};
            pin_i <= rnd();
            repeat (8) @(posedge clk_i);
            chk("pin_oe", 32'(gpap_pkg::ALT_OUT), 32'(pin_oe_o));
            chk("pin_o", 32'(pe), 32'(pin_o & gpap_pkg::ALT_OUT));
            chk("irq", 32'(pin_i[4:2]), 32'(expander_irq_n_o));
            rd(gpap_pkg::OFS_FUNC, 11'h7FF);
            rd(gpap_pkg::OFS_DATA, pin_i);
        end
        // A reset in mid-run must drop every pin back to a plain input.
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("pin_oe", 32'h0, 32'(pin_oe_o));
        chk("pin_o", 32'h0, 32'(pin_o));
        chk("irq", 32'h7, 32'(expander_irq_n_o));
        rd(gpap_pkg::OFS_FUNC, 11'h000);
        rd(gpap_pkg::OFS_DIR, 11'h000);
        wr(gpap_pkg::OFS_FUNC, 11'h000);
        wr(gpap_pkg::OFS_DIR, 11'h000);
        pin_i <= 11'h000;
        repeat (8) @(posedge clk_i);
        chk("irq", 32'h7, 32'(expander_irq_n_o));
        chk("pin_oe", 32'h0, 32'(pin_oe_o));
        rd(gpap_pkg::OFS_DATA, 11'h000);
        repeat (3) @(posedge clk_i);
        wrap_up();
    end
endmodule
